// ==== shared/scd_pkg.sv ====
// constants, types and error-class table for the switch and indicator block
package scd_pkg;
    localparam int SW_DIAG_HI = 2;
    localparam int SW_MODE1 = 3;
    localparam int SW_SWAP = 4;
    localparam int SW_TWO = 7;
    localparam logic [7:0] SW_FACTORY = 8'h80;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLINK_PERIOD_MS = 1000;
    localparam int BLINK_TIMEOUT_S = 120;
    localparam int HALF_CYCLES =
        BLINK_PERIOD_MS * 1000000 / 2 / CLK_PERIOD_NS;
    localparam logic [7:0] BLINK_TICKS =
        8'(BLINK_TIMEOUT_S * 1000 / (BLINK_PERIOD_MS / 2));
    // detailed error codes, octal value held in a byte
    localparam logic [7:0] EC_HOME0 = 8'h08;
    localparam logic [7:0] EC_HOME1 = 8'h10;
    localparam logic [7:0] EC_TRK0_IN = 8'h18;
    localparam logic [7:0] EC_ADDR = 8'h20;
    localparam logic [7:0] EC_TRK0 = 8'h28;
    localparam logic [7:0] EC_NOSECT = 8'h38;
    localparam logic [7:0] EC_WPROT = 8'h40;
    localparam logic [7:0] EC_NORDATA = 8'h48;
    localparam logic [7:0] EC_NOPRE = 8'h50;
    localparam logic [7:0] EC_NOIDAM = 8'h58;
    localparam logic [7:0] EC_HDRCHK = 8'h60;
    localparam logic [7:0] EC_SEEK = 8'h68;
    localparam logic [7:0] EC_IDTRIES = 8'h70;
    localparam logic [7:0] EC_NODAM = 8'h78;
    localparam logic [7:0] EC_DATCHK = 8'h80;
    localparam logic [7:0] EC_PARITY = 8'h88;
    localparam logic [7:0] EC_RWTEST = 8'h90;
    localparam logic [7:0] EC_WCOUNT = 8'h98;
    localparam logic [7:0] EC_DENSITY = 8'ha0;
    localparam logic [7:0] EC_KEY = 8'ha8;
    localparam logic [7:0] EC_INDET = 8'hb0;
    localparam logic [7:0] EC_WFMT = 8'hb8;
    localparam logic [7:0] EC_RWWR = 8'hd0;
    localparam logic [7:0] EC_RWRST = 8'hd8;
    localparam logic [7:0] EC_SYNC = 8'he0;
    localparam logic [7:0] EC_NOMEM = 8'he8;
    localparam logic [7:0] EC_NRDY = 8'hf0;
    localparam logic [7:0] EC_ACLOW = 8'hf8;
    localparam logic [3:0] CLS_NONE = 4'h0;

    typedef struct packed {
        logic normal;
        logic mode1;
        logic swap;
        logic two_drives;
    } scd_cfg_type;

    typedef struct packed {
        scd_cfg_type cfg;
        logic loaded;
        logic [3:0] cls;
        logic [7:0] code;
        logic err_drive;
        logic blink_on;
        logic phase;
        logic [7:0] ticks;
        logic [31:0] div;
        logic [8:0] leds;
        logic [1:0] drv_leds;
        logic [7:0] code_out;
        logic code_valid;
    } scd_state_type;

    function automatic scd_cfg_type cfg_decode(input logic [7:0] sw);
        scd_cfg_type c;
        c.normal = (sw[SW_DIAG_HI:0] == 3'h0);
        c.mode1 = sw[SW_MODE1];
        c.swap = sw[SW_SWAP];
        c.two_drives = sw[SW_TWO];
        return c;
    endfunction : cfg_decode

    // unknown codes give CLS_NONE and are not recorded
    function automatic logic [3:0] class_of(input logic [7:0] ec);
        logic [3:0] k;
        k = CLS_NONE;
        unique case (ec)
            EC_WPROT, EC_NRDY: k = 4'h1;
            EC_DENSITY, EC_KEY: k = 4'h2;
            EC_ADDR: k = 4'h3;
            EC_WCOUNT, EC_NOMEM: k = 4'h4;
            EC_INDET: k = 4'h5;
            EC_SEEK: k = 4'h6;
            EC_HDRCHK: k = 4'h7;
            EC_DATCHK: k = 4'h8;
            EC_NOSECT, EC_NOPRE, EC_NOIDAM,
            EC_IDTRIES, EC_NODAM: k = 4'h9;
            EC_NORDATA: k = 4'ha;
            EC_RWTEST, EC_RWWR, EC_RWRST: k = 4'hb;
            EC_SYNC: k = 4'hc;
            EC_HOME0, EC_HOME1, EC_TRK0_IN,
            EC_TRK0: k = 4'hd;
            EC_PARITY: k = 4'he;
            EC_WFMT, EC_ACLOW: k = 4'hf;
            default: k = CLS_NONE;
        endcase
        return k;
    endfunction : class_of
endpackage : scd_pkg

// ==== rtl/scd_top.sv ====
// switch decoder, indicator drive and drive-error blinker
`timescale 1ns/1ps
`default_nettype none
module scd_top
    import scd_pkg::*;
#(
    parameter int unsigned HALF_PERIOD = HALF_CYCLES
)(
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_SWITCH,
    input wire logic I_HOST_INIT,
    input wire logic I_HOST_CONNECTED,
    input wire logic I_WAIT_HOST,
    input wire logic I_WRITING,
    input wire logic I_READING,
    input wire logic I_SEQ_RUN,
    input wire logic [1:0] I_DRIVE_ACT,
    input wire logic I_ERR_VALID,
    input wire logic [7:0] I_ERR_CODE,
    input wire logic I_ERR_DRIVE,
    input wire logic I_ERR_FLAG,
    input wire logic I_ERR_FETCH,
    output scd_cfg_type O_CFG,
    output logic [8:0] O_LED,
    output logic [1:0] O_DRIVE_LED,
    output logic [7:0] O_ERR_CODE,
    output logic O_ERR_CODE_VALID
);
    scd_state_type s_q;
    scd_state_type s_d;
    logic tick;
    logic [3:0] new_cls;
    logic [1:0] act;

    assign new_cls = class_of(I_ERR_CODE);

    // next state; an error arriving with initialize wins over the clear
    always_comb
    begin
        s_d = s_q;
        tick = 1'b0;
        act = 2'b00;
        // free half-second enable for the blinker
        if (s_q.div == 32'(HALF_PERIOD - 1))
        begin
            s_d.div = '0;
            tick = 1'b1;
        end
        else
        begin
            s_d.div = s_q.div + 32'h1;
        end
        // switches read once after reset and on each initialize only,
        // so a bumped switch cannot disturb a running transfer
        if (!s_q.loaded || I_HOST_INIT)
        begin
            s_d.cfg = cfg_decode(I_SWITCH);
            s_d.loaded = 1'b1;
        end
        if (I_HOST_INIT)
        begin
            s_d.cls = CLS_NONE;
            s_d.code = '0;
            s_d.blink_on = 1'b0;
            s_d.phase = 1'b0;
        end
        else if (s_q.blink_on && tick)
        begin
            s_d.phase = ~s_q.phase;
            s_d.ticks = s_q.ticks + 8'h1;
            if (s_q.ticks == BLINK_TICKS - 8'h1)
            begin
                s_d.blink_on = 1'b0;
            end
        end
        if (I_ERR_VALID && new_cls != CLS_NONE)
        begin
            s_d.cls = new_cls;
            s_d.code = I_ERR_CODE;
            // density errors do not start the blinker; the blinking drive
            // only moves when a newer flagged error takes over
            if (I_ERR_FLAG && I_ERR_CODE != EC_DENSITY)
            begin
                s_d.err_drive = I_ERR_DRIVE;
                s_d.blink_on = 1'b1;
                s_d.phase = 1'b1;
                s_d.ticks = '0;
            end
        end
        // detailed code handed out on request
        s_d.code_valid = I_ERR_FETCH;
        if (I_ERR_FETCH)
        begin
            s_d.code_out = s_q.code;
        end
        // controller indicators 1 to 8 only meaningful in normal mode; the run indicator shows in every mode
        s_d.leds[0] = s_q.cfg.normal & I_HOST_CONNECTED;
        s_d.leds[1] = s_q.cfg.normal & I_WAIT_HOST;
        s_d.leds[2] = s_q.cfg.normal & I_WRITING;
        s_d.leds[3] = s_q.cfg.normal & I_READING;
        s_d.leds[4] = s_q.cfg.normal & s_d.cls[3];
        s_d.leds[5] = s_q.cfg.normal & s_d.cls[2];
        s_d.leds[6] = s_q.cfg.normal & s_d.cls[1];
        s_d.leds[7] = s_q.cfg.normal & s_d.cls[0];
        s_d.leds[8] = I_SEQ_RUN;
        // logical drive activity; a lone drive hides drive 1
        act[0] = I_DRIVE_ACT[0];
        act[1] = I_DRIVE_ACT[1] & s_q.cfg.two_drives;
        if (s_q.blink_on)
        begin
            act[s_q.err_drive] = s_q.phase;
        end
        // physical left is index 0
        s_d.drv_leds[0] = s_q.cfg.swap ? act[1] : act[0];
        s_d.drv_leds[1] = s_q.cfg.swap ? act[0] : act[1];
    end

    // single state register
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            s_q <= '0;
            s_q.cfg <= cfg_decode(SW_FACTORY);
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign O_CFG = s_q.cfg;
    assign O_LED = s_q.leds;
    assign O_DRIVE_LED = s_q.drv_leds;
    assign O_ERR_CODE = s_q.code_out;
    assign O_ERR_CODE_VALID = s_q.code_valid;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    property p_normal_sel;
        I_HOST_INIT |=> O_CFG.normal == ($past(I_SWITCH[2:0]) == 3'h0);
    endproperty
    a_normal_sel: assert property (p_normal_sel)
        else $error("normal mode not decoded from switches 1-3");

    property p_mode_sel;
        I_HOST_INIT |=> O_CFG.mode1 == $past(I_SWITCH[3]);
    endproperty
    a_mode_sel: assert property (p_mode_sel)
        else $error("programming mode not taken from switch 4");

    property p_cfg_hold;
        (s_q.loaded && !I_HOST_INIT) |=> $stable(O_CFG);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration changed without initialize");

    property p_swap;
        (s_q.loaded && O_CFG.swap && !s_q.blink_on && !I_HOST_INIT)
            |=> O_DRIVE_LED[1] == $past(I_DRIVE_ACT[0]);
    endproperty
    a_swap: assert property (p_swap)
        else $error("swapped mapping wrong on right drive");

    property p_one_drive;
        (s_q.loaded && !O_CFG.two_drives && !O_CFG.swap
            && !s_q.blink_on && !I_HOST_INIT) |=> !O_DRIVE_LED[1];
    endproperty
    a_one_drive: assert property (p_one_drive)
        else $error("second drive shown with one drive configured");

    property p_host_led;
        (O_CFG.normal && I_HOST_CONNECTED) |=> O_LED[0];
    endproperty
    a_host_led: assert property (p_host_led)
        else $error("indicator 1 dark in normal mode");

    property p_write_led;
        !I_WRITING |=> !O_LED[2];
    endproperty
    a_write_led: assert property (p_write_led)
        else $error("indicator 3 lit with no write");

    property p_class_show;
        (O_CFG.normal && I_ERR_VALID && class_of(I_ERR_CODE) != 4'h0
            && !I_HOST_INIT) |=> {O_LED[4], O_LED[5], O_LED[6],
            O_LED[7]} == class_of($past(I_ERR_CODE));
    endproperty
    a_class_show: assert property (p_class_show)
        else $error("error class not shown next cycle");

    property p_init_clear;
        (I_HOST_INIT && !I_ERR_VALID) |=> O_LED[7:4] == 4'h0
            && s_q.code == 8'h00 && !s_q.blink_on;
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("class not cleared by initialize");

    property p_blink_bound;
        s_q.blink_on |-> s_q.ticks < BLINK_TICKS;
    endproperty
    a_blink_bound: assert property (p_blink_bound)
        else $error("blinker ran past its timeout");

    property p_run_led;
        I_SEQ_RUN |=> O_LED[8];
    endproperty
    a_run_led: assert property (p_run_led)
        else $error("run indicator dark while sequencer runs");

    property p_run_off;
        !I_SEQ_RUN |=> !O_LED[8];
    endproperty
    a_run_off: assert property (p_run_off)
        else $error("run indicator lit while sequencer halted");

    // reset value must be the shipped switch pattern
    property p_factory;
        $rose(I_RST_N) |-> O_CFG == cfg_decode(SW_FACTORY);
    endproperty
    a_factory: assert property (p_factory)
        else $error("configuration after reset is not the factory one");

    property p_cfg_fields;
        I_HOST_INIT |=> O_CFG.swap == $past(I_SWITCH[SW_SWAP])
            && O_CFG.two_drives == $past(I_SWITCH[SW_TWO]);
    endproperty
    a_cfg_fields: assert property (p_cfg_fields)
        else $error("drive mapping or count not taken from switches");

    property p_straight;
        (s_q.loaded && !O_CFG.swap && !s_q.blink_on)
            |=> O_DRIVE_LED[0] == $past(I_DRIVE_ACT[0]);
    endproperty
    a_straight: assert property (p_straight)
        else $error("unswapped mapping wrong on left drive");

    property p_swap_left;
        (s_q.loaded && O_CFG.swap && !s_q.blink_on)
            |=> O_DRIVE_LED[0] == ($past(I_DRIVE_ACT[1])
            && $past(O_CFG.two_drives));
    endproperty
    a_swap_left: assert property (p_swap_left)
        else $error("swapped mapping wrong on left drive");

    property p_two_drive;
        (s_q.loaded && O_CFG.two_drives && !O_CFG.swap && !s_q.blink_on)
            |=> O_DRIVE_LED[1] == $past(I_DRIVE_ACT[1]);
    endproperty
    a_two_drive: assert property (p_two_drive)
        else $error("second drive activity lost with two drives");

    // diagnostic mode leaves indicators 1 to 8 to the test routines
    property p_diag_dark;
        !O_CFG.normal |=> O_LED[7:0] == 8'h00;
    endproperty
    a_diag_dark: assert property (p_diag_dark)
        else $error("normal-mode indicators lit outside normal mode");

    property p_wait_led;
        O_CFG.normal |=> O_LED[1] == $past(I_WAIT_HOST);
    endproperty
    a_wait_led: assert property (p_wait_led)
        else $error("indicator 2 does not follow host wait");

    property p_read_led;
        O_CFG.normal |=> O_LED[3] == $past(I_READING);
    endproperty
    a_read_led: assert property (p_read_led)
        else $error("indicator 4 does not follow diskette read");

    property p_code_keep;
        (I_ERR_VALID && class_of(I_ERR_CODE) != CLS_NONE)
            |=> s_q.code == $past(I_ERR_CODE);
    endproperty
    a_code_keep: assert property (p_code_keep)
        else $error("detailed code not stored with its error");

    property p_fetch_answer;
        I_ERR_FETCH |=> O_ERR_CODE_VALID && O_ERR_CODE == $past(s_q.code);
    endproperty
    a_fetch_answer: assert property (p_fetch_answer)
        else $error("fetch did not return the stored code");

    property p_fetch_pulse;
        !I_ERR_FETCH |=> !O_ERR_CODE_VALID;
    endproperty
    a_fetch_pulse: assert property (p_fetch_pulse)
        else $error("code valid raised without a fetch");

    property p_blink_start;
        (I_ERR_VALID && I_ERR_FLAG && class_of(I_ERR_CODE) != CLS_NONE
            && I_ERR_CODE != EC_DENSITY) |=> s_q.blink_on && s_q.phase
            && s_q.err_drive == $past(I_ERR_DRIVE);
    endproperty
    a_blink_start: assert property (p_blink_start)
        else $error("flagged error did not start the blinker");

    property p_density_quiet;
        (I_ERR_VALID && I_ERR_CODE == EC_DENSITY && !s_q.blink_on)
            |=> !s_q.blink_on;
    endproperty
    a_density_quiet: assert property (p_density_quiet)
        else $error("density error started the blinker");
endmodule : scd_top
`default_nettype wire

// ==== dv/scd_host_model.sv ====
// host-side model: initialize and code-fetch pulses over the cable bus
`timescale 1ns/1ps
`default_nettype none
module scd_host_model (
    input wire logic i_clk,
    output logic o_init,
    output logic o_fetch
);
    // quiet at time zero so the block sees no stray initialize
    initial
    begin
        o_init = 1'b0;
        o_fetch = 1'b0;
    end

    // pulse launched at the caller's edge, dropped at the next edge
    task automatic pulse(input logic init, input logic fetch);
        o_init <= init;
        o_fetch <= fetch;
        @(posedge i_clk);
        o_init <= 1'b0;
        o_fetch <= 1'b0;
    endtask : pulse
endmodule : scd_host_model
`default_nettype wire

// ==== dv/test_scd_top.sv ====
// self-checking bench for the switch and indicator block
`timescale 1ns/1ps
`default_nettype none
module test_scd_top;
    import scd_pkg::*;
    localparam int unsigned HP = 4;
    // code in the upper byte, expected class in the low nibble
    localparam logic [11:0] TBL [28] = '{12'h08d, 12'h10d, 12'h18d,
        12'h203, 12'h28d, 12'h389, 12'h401, 12'h48a, 12'h509, 12'h589,
        12'h607, 12'h686, 12'h709, 12'h789, 12'h808, 12'h88e, 12'h90b,
        12'h984, 12'ha02, 12'ha82, 12'hb05, 12'hb8f, 12'hd0b, 12'hd8b,
        12'he0c, 12'he84, 12'hf01, 12'hf8f};
    logic I_CLK = 1'b0;
    logic I_RST_N = 1'b0;
    logic [7:0] sw = 8'h00;
    logic [4:0] st = 5'h00;
    logic [1:0] act = 2'h0;
    logic err_v = 1'b0;
    logic [7:0] err_c = 8'h00;
    logic err_d = 1'b0;
    logic err_f = 1'b0;
    wire logic init_w;
    wire logic fetch_w;
    scd_cfg_type cfg;
    logic [8:0] led;
    logic [1:0] dled;
    logic [7:0] ecode;
    logic evld;
    logic [7:0] s;
    logic [1:0] l;
    logic prev;
    int tg;
    int error_cnt = 0;
    int checked = 0;

    scd_top #(.HALF_PERIOD(HP)) dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
        .I_SWITCH(sw), .I_HOST_INIT(init_w), .I_HOST_CONNECTED(st[4]),
        .I_WAIT_HOST(st[3]), .I_WRITING(st[2]), .I_READING(st[1]),
        .I_SEQ_RUN(st[0]), .I_DRIVE_ACT(act), .I_ERR_VALID(err_v),
        .I_ERR_CODE(err_c), .I_ERR_DRIVE(err_d), .I_ERR_FLAG(err_f),
        .I_ERR_FETCH(fetch_w), .O_CFG(cfg), .O_LED(led),
        .O_DRIVE_LED(dled), .O_ERR_CODE(ecode), .O_ERR_CODE_VALID(evld));

    scd_host_model host (.i_clk(I_CLK), .o_init(init_w), .o_fetch(fetch_w));

    // free-running 100 MHz clock
    always #5 I_CLK = ~I_CLK;

    function automatic logic [3:0] exp_cfg(input logic [7:0] v);
        return {v[2:0] == 3'h0, v[3], v[4], v[7]};
    endfunction : exp_cfg

    // class nibble as it appears on led 5..8, led 5 being the msb
    function automatic logic [3:0] rev4(input logic [3:0] c);
        return {c[0], c[1], c[2], c[3]};
    endfunction : rev4

    task automatic chk(input string nm, input logic [8:0] seen,
        input logic [8:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // switches change right after sampling, so a late read shows up
    task automatic init(input logic [7:0] v);
        @(posedge I_CLK);
        sw <= v;
        host.pulse(1'b1, 1'b0);
        sw <= ~v;
    endtask : init

    task automatic err(input logic [7:0] c, input logic d, input logic f);
        @(posedge I_CLK);
        err_v <= 1'b1;
        err_c <= c;
        err_d <= d;
        err_f <= f;
        @(posedge I_CLK);
        err_v <= 1'b0;
        #1;
    endtask : err

    // checks dark drive leds for eight cycles; blinking would show in four
    task automatic dark8();
        repeat (8)
        begin
            @(posedge I_CLK);
            #1 chk("drive led dark", 9'(dled), 9'h0);
        end
    endtask : dark8

    // counts changes of the left drive led over n cycles into tg
    task automatic toggles(input int n);
        tg = 0;
        prev = dled[0];
        repeat (n)
        begin
            @(posedge I_CLK);
            #1;
            if (dled[0] !== prev)
                tg++;
            prev = dled[0];
        end
    endtask : toggles

    // main sequence
    initial
    begin
        void'($urandom(72454));
        repeat (5) @(posedge I_CLK);
        #1 chk("cfg in reset", 9'(cfg), 9'(exp_cfg(SW_FACTORY)));
        chk("led in reset", led, 9'h0);
        repeat (5) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            s = (i == 0) ? 8'h80 : 8'($urandom);
            if (i[0])
                s[2:0] = 3'h0;
            init(s);
            st <= 5'($urandom);
            act <= 2'($urandom);
            #1 chk("cfg", 9'(cfg), 9'(exp_cfg(s)));
            @(posedge I_CLK);
            #1 chk("cfg held", 9'(cfg), 9'(exp_cfg(s)));
            chk("led", led, {st[0], 4'h0, (s[2:0] == 3'h0) ?
                {st[1], st[2], st[3], st[4]} : 4'h0});
            l = {act[1] & s[7], act[0]};
            if (s[2:0] == 3'h0)
                chk("drive led", 9'(dled), 9'(s[4] ? {l[0], l[1]} : l));
        end
        init(8'h80);
        st <= 5'h10;
        act <= 2'h0;
        for (int k = 0; k < 28; k++)
        begin
            err(TBL[k][11:4], 1'(k), 1'b0);
            chk("class", 9'(led[7:4]), 9'(rev4(TBL[k][3:0])));
            chk("fetch valid drop", 9'(evld), 9'h0);
            @(posedge I_CLK);
            host.pulse(1'b0, 1'b1);
            #1 chk("fetch valid", 9'(evld), 9'h1);
            chk("fetch code", 9'(ecode), 9'(TBL[k][11:4]));
        end
        err(8'h00, 1'b0, 1'b0);
        chk("unknown code", 9'(led[7:4]), 9'hf);
        init(8'h80);
        #1 chk("class cleared", 9'(led[7:4]), 9'h0);
        @(posedge I_CLK);
        host.pulse(1'b0, 1'b1);
        #1 chk("code cleared", 9'(ecode), 9'h0);
        err(EC_DATCHK, 1'b0, 1'b1);
        // the drive led follows the registered blinker, a cycle later
        @(posedge I_CLK);
        #1 chk("blink start", 9'(dled), 9'h1);
        toggles(40);
        chk("blink toggles", 9'(tg), 9'(40 / HP));
        // still blinking a few toggles before the timeout runs out
        repeat (BLINK_TICKS * HP - 60) @(posedge I_CLK);
        #1 toggles(8);
        chk("blink late", 9'(tg), 9'(8 / HP));
        repeat (100) @(posedge I_CLK);
        #1 chk("blink timeout", 9'(dled), 9'h0);
        init(8'h90);
        err(EC_NOSECT, 1'b0, 1'b1);
        @(posedge I_CLK);
        #1 chk("blink swapped", 9'(dled), 9'h2);
        init(8'h90);
        @(posedge I_CLK);
        dark8();
        err(EC_DENSITY, 1'b1, 1'b1);
        dark8();
        // error and initialize in one cycle: the error must survive
        @(posedge I_CLK);
        err_v <= 1'b1;
        err_c <= EC_SEEK;
        err_f <= 1'b0;
        host.pulse(1'b1, 1'b0);
        err_v <= 1'b0;
        #1 chk("error beats init", 9'(led[7:4]), 9'(rev4(4'h6)));
        finish_test();
    end

    // watchdog: the sequence needs about 1250 cycles
    initial
    begin
        #200000;
        error_cnt++;
        finish_test();
    end
endmodule : test_scd_top
`default_nettype wire
